// ---- common/pllcd_pkg.sv ----
// How it works
// R1 - pll multiplies reference by 5 to 64
// R2 - multiplier resets to six
// R3 - system clock divides vco by 1..15
// R4 - system divider change needs no relock
// R5 - core divider codes give 1,2,4,8
// R6 - buffered copy of reference clock out
// R7 - system clock output at system rate
// R8 - clock output on after reset, disableable
// R9 - peripherals on system, core on core clock
// R10 - software keeps system clock under maximum
// R11 - bypass runs both clocks at reference
// R12 - multiplier written in bypass applies later
// R13 - divider changes land on clock boundaries
`default_nettype none
package pllcd_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_MULT = 8'h00;
    localparam logic [7:0] ADDR_DIV  = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    // multiplier limits and reset value
    localparam logic [6:0] MULT_MIN   = 7'h05;
    localparam logic [6:0] MULT_MAX   = 7'h40;
    localparam logic [6:0] MULT_RESET = 7'h06;
    // divisor register fields
    localparam int SSEL_LSB = 0;
    localparam int CSEL_LSB = 4;
    localparam logic [3:0] SSEL_RESET = 4'h5;
    localparam logic [1:0] CSEL_RESET = 2'h0;
    // control register fields
    localparam int CTRL_BYPASS = 0;
    localparam int CTRL_CKOEN  = 1;
endpackage
`default_nettype wire

// ---- testbench/pllcd_tick_mon.sv ----
`default_nettype none
// clock consumer model: measures spacing of the core and peripheral enables
module pllcd_tick_mon (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       sys_tick,     // peripheral clock enable
    input  wire logic       core_tick,    // core clock enable
    output logic      [7:0] sys_period,   // cycles between peripheral ticks
    output logic      [7:0] core_period   // cycles between core ticks
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sys_cnt_r;  // cycles since last peripheral tick
    logic [7:0] core_cnt_r; // cycles since last core tick
    // period latched on each tick, so a truncated pulse shows as a short period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sys_cnt_r, core_cnt_r, sys_period, core_period} <= 32'h0;
        end else begin
            sys_cnt_r  <= sys_tick ? 8'h0 : sys_cnt_r + 8'h1;
            core_cnt_r <= core_tick ? 8'h0 : core_cnt_r + 8'h1;
            if (sys_tick) sys_period <= sys_cnt_r + 8'h1;
            if (core_tick) core_period <= core_cnt_r + 8'h1;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/pllcd_top_tb.sv ----
`default_nettype none
module pllcd_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, ref_clock_in, ref_tick;
    logic [7:0] paddr, sys_period, core_period;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, buffered_ref_out, sys_clock_out, sys_tick, core_tick;
    logic periph_clock, core_clock;
    logic [6:0] active_mult;
    logic [1:0] ref_cnt;       // reference runs at a third of pclk
    int err_total, checks;
    pllcd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_clock_in(ref_clock_in),
        .ref_tick(ref_tick), .active_mult(active_mult),
        .buffered_ref_out(buffered_ref_out), .sys_clock_out(sys_clock_out),
        .sys_tick(sys_tick), .core_tick(core_tick), .periph_clock(periph_clock),
        .core_clock(core_clock));
    pllcd_tick_mon mon_u (.pclk(pclk), .presetn(presetn), .sys_tick(sys_tick),
        .core_tick(core_tick), .sys_period(sys_period), .core_period(core_period));
    // 10 MHz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // reference pulse every third cycle
    always @(posedge pclk) begin
        ref_cnt <= (ref_cnt == 2'h2) ? 2'h0 : ref_cnt + 2'h1;
        ref_tick <= (ref_cnt == 2'h2);
        ref_clock_in <= (ref_cnt != 2'h0);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; waits for pready rather than assuming a latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic close_out();
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog well beyond the roughly 760 cycles of tests
    initial begin
        repeat (6000) @(posedge pclk);
        err_total++;
        close_out();
    end
    initial begin
        logic [31:0] wv [4];
        logic [31:0] ev [4];
        wv = '{32'h5, 32'h40, 32'h4, 32'h41};
        ev = '{32'h5, 32'h40, 32'h40, 32'h40};
        {presetn, psel, penable, pwrite, paddr, pwdata, ref_cnt} = '0;
        {ref_tick, ref_clock_in, err_total, checks} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk(active_mult, 32'h6);
        apb(1'b0, pllcd_pkg::ADDR_DIV, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, pllcd_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h2);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, pllcd_pkg::ADDR_MULT, wv[i]);
            apb(1'b0, pllcd_pkg::ADDR_MULT, 32'h0);
            chk(rd, ev[i]);
        end
        // every legal divider setting, cycling the core codes alongside
        for (int s = 1; s < 16; s++) begin
            apb(1'b1, pllcd_pkg::ADDR_DIV, 32'(s) | (32'(s % 4) << 4));
            repeat (40) @(posedge pclk);
            chk(sys_period, 32'(s));
            chk(core_period, 32'h1 << (s % 4));
            @(negedge pclk);
            chk(sys_clock_out, periph_clock);
        end
        // bypass: both clocks follow the reference, multiplier held back
        apb(1'b1, pllcd_pkg::ADDR_CTRL, 32'h3);
        apb(1'b1, pllcd_pkg::ADDR_MULT, 32'h14);
        repeat (40) @(posedge pclk);
        chk(active_mult, 32'h40);
        chk({sys_period, core_period}, 32'h0303);
        @(negedge pclk);
        chk({core_clock, periph_clock}, {2{ref_clock_in}});
        chk(buffered_ref_out, ref_clock_in);
        apb(1'b1, pllcd_pkg::ADDR_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        chk(active_mult, 32'h14);
        apb(1'b0, pllcd_pkg::ADDR_STAT, 32'h0);
        chk(rd, 32'h14);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        repeat (8) begin
            @(negedge pclk);
            chk(sys_clock_out, 32'h0);
        end
        close_out();
    end
endmodule
`default_nettype wire

// ---- verilog/pllcd_divider.sv ----
`default_nettype none
// even-or-odd divider producing a clock enable pulse and level clock;
// a new ratio is loaded only when the count wraps so no pulse is cut short
module pllcd_divider #(
    parameter int W = 4
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] ratio,    // divide ratio, 0 treated as 1
    output logic              tick,     // one pulse per output period
    output logic              clk_out   // divided level clock
);
    logic [W-1:0] cnt_r;     // position inside current period
    logic [W-1:0] active_r;  // ratio in use for current period
    logic [W-1:0] eff;
    logic [W:0]   pos_w;     // one bit wider to match half_w; count is at most 14 so plus one never wraps
    logic [W:0]   half_w;    // rounded-up half period, same widening

    assign pos_w  = {1'b0, cnt_r} + {{W{1'b0}}, 1'b1};
    assign half_w = ({1'b0, active_r} + {{W{1'b0}}, 1'b1}) >> 1;

    assign eff  = (ratio == '0) ? W'(1) : ratio;
    assign tick = (cnt_r == '0);

    // counter and boundary reload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r    <= '0;
            active_r <= W'(1);
        end else if (cnt_r >= active_r - W'(1)) begin
            cnt_r    <= '0;
            active_r <= eff; // [R13]
        end else begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    // high for first half of each period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out <= 1'b0;
        end else begin
            clk_out <= (cnt_r >= active_r - W'(1)) ? 1'b1
                     : (pos_w < half_w);
        end
    end
endmodule
`default_nettype wire

// ---- verilog/pllcd_top.sv ----
`default_nettype none
// clock control model: no separate vco input is modelled, pclk stands in for it;
// dividers run as enables in pclk domain
module pllcd_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ref_clock_in,     // reference level
    input  wire logic        ref_tick,         // one pulse per reference cycle
    output logic [6:0]       active_mult,      // multiplier the pll runs at
    output logic             buffered_ref_out,
    output logic             sys_clock_out,
    output logic             sys_tick,         // peripheral clock enable
    output logic             core_tick,        // core clock enable
    output logic             periph_clock,
    output logic             core_clock
);
    logic [6:0] mult_r;     // programmed multiplier
    logic [6:0] act_mult_r; // multiplier applied to the pll
    logic [3:0] ssel_r;     // system divider select
    logic [1:0] csel_r;     // core divider select
    logic       bypass_r;   // pll bypass
    logic       ckoen_r;    // system clock output enable
    logic       wr_en;
    logic [3:0] core_ratio;
    logic       s_tick, s_clk, c_tick, c_clk;

    assign pready  = 1'b1; // zero wait states
    assign pslverr = 1'b0;
    assign wr_en   = psel & penable & pwrite;

    // writes to control state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_r   <= pllcd_pkg::MULT_RESET; // [R2]
            ssel_r   <= pllcd_pkg::SSEL_RESET;
            csel_r   <= pllcd_pkg::CSEL_RESET;
            bypass_r <= 1'b0;
            ckoen_r  <= 1'b1; // [R8]
        end else if (wr_en) begin
            unique case (paddr)
                pllcd_pkg::ADDR_MULT: begin
                    // out-of-range values ignored to keep vco legal
                    if (pwdata[6:0] >= pllcd_pkg::MULT_MIN &&
                        pwdata[6:0] <= pllcd_pkg::MULT_MAX) begin
                        mult_r <= pwdata[6:0]; // [R1]
                    end
                end
                pllcd_pkg::ADDR_DIV: begin
                    // each field takes effect at its own divider's next wrap, no relock wait
                    ssel_r <= pwdata[pllcd_pkg::SSEL_LSB +: 4]; // [R4] [R3]
                    csel_r <= pwdata[pllcd_pkg::CSEL_LSB +: 2]; // [R5]
                end
                pllcd_pkg::ADDR_CTRL: begin
                    bypass_r <= pwdata[pllcd_pkg::CTRL_BYPASS];
                    ckoen_r  <= pwdata[pllcd_pkg::CTRL_CKOEN]; // [R8]
                end
                default: begin
                end
            endcase
        end
    end

    // multiplier reaches pll only outside bypass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_mult_r <= pllcd_pkg::MULT_RESET;
        end else if (!bypass_r) begin
            act_mult_r <= mult_r; // [R12]
        end
    end
    assign active_mult = act_mult_r; // [R1]

    // read mux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                pllcd_pkg::ADDR_MULT: prdata <= {25'h0, mult_r};
                pllcd_pkg::ADDR_DIV:  prdata <= {26'h0, csel_r, ssel_r};
                pllcd_pkg::ADDR_CTRL: prdata <= {30'h0, ckoen_r, bypass_r};
                pllcd_pkg::ADDR_STAT: prdata <= {25'h0, act_mult_r};
                default:              prdata <= 32'h00000000;
            endcase
        end
    end

    assign core_ratio = 4'h1 << csel_r; // [R5]

    // system divider
    pllcd_divider #(.W(4)) u_sys (
        .pclk    (pclk),
        .presetn (presetn),
        .ratio   (ssel_r),
        .tick    (s_tick),
        .clk_out (s_clk)
    );
    // core divider
    pllcd_divider #(.W(4)) u_core (
        .pclk    (pclk),
        .presetn (presetn),
        .ratio   (core_ratio),
        .tick    (c_tick),
        .clk_out (c_clk)
    );

    // bypass routes the reference straight to both clocks
    assign core_clock   = bypass_r ? ref_clock_in : c_clk;  // [R11]
    assign periph_clock = bypass_r ? ref_clock_in : s_clk;  // [R9] [R11]
    assign core_tick    = bypass_r ? ref_tick : c_tick;     // [R9]
    assign sys_tick     = bypass_r ? ref_tick : s_tick;
    assign buffered_ref_out = ref_clock_in;                 // [R6]
    assign sys_clock_out    = ckoen_r & periph_clock;       // [R7] [R8]

    // default multiplier after reset
    AST_MULT_RESET: assert property (@(posedge pclk) $rose(presetn) |-> mult_r == pllcd_pkg::MULT_RESET) // [R2]
        else $error("multiplier not six after reset");
    AST_MULT_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        act_mult_r >= pllcd_pkg::MULT_MIN && act_mult_r <= pllcd_pkg::MULT_MAX) // [R1]
        else $error("multiplier out of range");
    AST_BYPASS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        bypass_r |=> $stable(act_mult_r)) // [R12]
        else $error("multiplier changed in bypass");
    AST_DIV_NOW: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == pllcd_pkg::ADDR_DIV |=> ssel_r == $past(pwdata[3:0])) // [R4]
        else $error("divisor not applied next cycle");
    AST_CKO_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !ckoen_r |-> !sys_clock_out) // [R8]
        else $error("clock output driven while disabled");
    AST_CORE_RATIO: assert property (@(posedge pclk) disable iff (!presetn)
        csel_r == 2'h3 |-> core_ratio == 4'h8) // [R5]
        else $error("core ratio wrong");
    AST_BYPASS_CLK: assert property (@(posedge pclk) disable iff (!presetn)
        bypass_r |-> core_clock == ref_clock_in && periph_clock == ref_clock_in) // [R11]
        else $error("bypass clocks not at reference");
    AST_BUF_REF: assert property (@(posedge pclk) disable iff (!presetn)
        buffered_ref_out == ref_clock_in) // [R6]
        else $error("buffered reference mismatch");
    AST_SYS_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        ckoen_r |-> sys_clock_out == periph_clock) // [R7]
        else $error("clock output not at system rate");
endmodule
`default_nettype wire
